// ==== core/afc_clkdiv.v ====
// Conversion clock prescaler: bus clock divided by 2*(value+1)
`timescale 1ns/1ps
`default_nettype none
`include "afc_defines.vh"

module afc_clkdiv (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       run,
    input  wire [6:0] clock_divider_value,
    output reg        conv_clk,
    output reg        conv_tick
);

    reg [6:0] cnt_r;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r     <= 7'h00;
            conv_clk  <= 1'b0;
            conv_tick <= 1'b0;
        end else if (!run) begin
            cnt_r     <= 7'h00;
            conv_clk  <= 1'b0;
            conv_tick <= 1'b0;
        end else if (cnt_r >= clock_divider_value) begin
            // Half period is value+1 bus cycles
            cnt_r     <= 7'h00;
            conv_clk  <= ~conv_clk;
            conv_tick <= ~conv_clk;
        end else begin
            cnt_r     <= cnt_r + 7'h01;
            conv_tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== core/afc_ctrl.v ====
// Converter timing, result format and conversion flow control
// Overview of operation
// - Conversion clock is bus clock over twice (prescaler plus one).
// - Prescaler writable only when converter disabled or special access set.
// - Results unsigned; format bit 7 picks left (0) or right (1).
// - Resolution 000 gives 8 bits, 010 gives 10 bits, rest reserved.
// - Reserved resolution at conversion start sets command error and halts.
// - Justify and resolution writable only when disabled or special access.
// - Flow bits modifiable only three bus cycles after enable.
// - All flow bits clear while disabled or on soft reset.
// - Flow bits set only while enabled; writing zero has no effect.
// - Restart mode: sampling two bus plus two conversion cycles after start.
// - Back to back: next sample five bus plus two conversion cycles.
// - Trigger mode: restart also starts; both bits clear together.
// - Trigger mode: sampling five bus cycles after start bit clears.
// - Abort bit ends sequence at boundary; clears once converter idle.
// - Bus: zero never clears abort; one while set flags overrun.
// - Interface abort request while abort set flags overrun.
// - Restart before end of list or abort forces abort, restart error.
// - Start bit begins sequence when idle; clears at first sample.
// - Bus: writing one while start set raises start overrun error.
// - Interface start request while start set raises start overrun error.
// - Restart reloads first command when idle; clears once loaded.
// - Load-ok marks alternate list; clears on swap; zero in single.
`timescale 1ns/1ps
`default_nettype none
`include "afc_defines.vh"

module afc_ctrl (
    input  wire       core_clk,
    input  wire       rst,
    input  wire [3:0] bus_addr,
    input  wire       bus_wr,
    input  wire       bus_rd,
    input  wire [7:0] bus_wdata,
    output reg  [7:0] bus_rdata,
    input  wire       adc_enable,
    input  wire       soft_reset,
    input  wire       special_access_unlock,
    input  wire [1:0] control_source_config,
    input  wire       trigger_mode,
    input  wire       command_list_buffer_mode,
    input  wire       intf_abort_req,
    input  wire       intf_start_req,
    input  wire       intf_restart_req,
    input  wire       intf_loadok,
    input  wire       first_cmd_loaded,
    input  wire       conv_period_end,
    input  wire       end_of_list,
    input  wire [3:0] error_flag_clear,
    output wire       conversion_clock,
    output wire       conversion_clock_tick,
    output reg        result_justify_select,
    output reg  [2:0] resolution_select,
    output wire       res_is_10bit,
    output wire       load_first_cmd,
    output wire       list_swap,
    output wire       sample_start,
    output wire       sequence_active,
    output wire       converter_idle,
    output reg        sequence_abort_bit,
    output reg        sequence_start_bit,
    output reg        list_restart_bit,
    output reg        alternate_list_loaded_bit,
    output wire       command_error_flag,
    output wire       start_overrun_error_flag,
    output wire       unexpected_restart_error_flag,
    output wire       flow_overrun_flag
);

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_LOAD = 5'h02;
    localparam [4:0] ST_WAIT = 5'h04;
    localparam [4:0] ST_CONV = 5'h08;
    localparam [4:0] ST_HALT = 5'h10;

    function res_reserved;
        input [2:0] code;
        begin
            res_reserved = (code != `AFC_RES_8BIT) &&
                           (code != `AFC_RES_10BIT);
        end
    endfunction

    reg  [4:0] state_r;
    reg  [4:0] state_nxt;
    reg  [6:0] prs_r;
    reg  [1:0] en_cnt_r;
    reg  [3:0] err_r;
    wire [3:0] err_set;
    reg        sequence_abort_bit_nxt;
    reg        sequence_start_bit_nxt;
    reg        list_restart_bit_nxt;
    reg        alternate_list_loaded_bit_nxt;
    reg        tmr_start;
    reg  [2:0] tmr_bus;
    reg  [1:0] tmr_conv;
    wire       tmr_done;

    wire clr_all  = !adc_enable || soft_reset;
    wire mod_ok   = adc_enable && (en_cnt_r == `AFC_EN_LATENCY);
    wire cfg_ok   = !adc_enable || special_access_unlock;
    wire src_bus  = (control_source_config == `AFC_SRC_BUS);
    wire src_intf = (control_source_config == `AFC_SRC_INTF);
    wire wr_prs   = bus_wr && (bus_addr == `AFC_OFS_PRESCALER);
    wire wr_fmt   = bus_wr && (bus_addr == `AFC_OFS_FORMAT);
    wire wr_flow  = bus_wr && (bus_addr == `AFC_OFS_FLOW) &&
                    src_bus && mod_ok;
    wire intf_ok  = src_intf && mod_ok;

    // Only ones act; a zero in a written bit leaves the flag alone
    wire req_abort   = (wr_flow && bus_wdata[`AFC_BIT_ABORT]) ||
                       (intf_ok && intf_abort_req);
    wire req_start   = (wr_flow && bus_wdata[`AFC_BIT_START]) ||
                       (intf_ok && intf_start_req);
    wire req_restart = (wr_flow && bus_wdata[`AFC_BIT_RESTART]) ||
                       (intf_ok && intf_restart_req);
    // Load-ok needs restart alongside it on either source
    wire req_alternate_list_loaded_bit    = (wr_flow && bus_wdata[`AFC_BIT_ALTERNATE_LIST_LOADED_BIT] &&
                        bus_wdata[`AFC_BIT_RESTART]) ||
                       (intf_ok && intf_restart_req && intf_loadok);

    wire st_idle = state_r[0];
    wire st_load = state_r[1];
    wire st_wait = state_r[2];
    wire st_conv = state_r[3];
    wire st_halt = state_r[4];

    wire loaded    = st_load && first_cmd_loaded;
    wire res_bad   = res_reserved(resolution_select);
    wire start_now = st_wait && tmr_done;
    wire boundary  = st_conv && conv_period_end;

    // A restart mid-sequence, not at end of list, forces an abort
    wire auto_abort = req_restart && (st_wait || st_conv) &&
                      !sequence_abort_bit &&
                      !(st_conv && end_of_list);

    assign load_first_cmd  = st_load;
    assign list_swap       = loaded && alternate_list_loaded_bit;
    assign sample_start    = start_now && !res_bad;
    assign sequence_active = st_load || st_wait || st_conv;
    assign converter_idle  = st_idle;
    assign res_is_10bit    = (resolution_select == `AFC_RES_10BIT);

    afc_clkdiv u_clkdiv (
        .core_clk            (core_clk),
        .rst                 (rst),
        .run                 (!clr_all),
        .clock_divider_value (prs_r),
        .conv_clk            (conversion_clock),
        .conv_tick           (conversion_clock_tick)
    );

    afc_timer u_timer (
        .core_clk    (core_clk),
        .rst         (rst),
        .start       (tmr_start),
        .cancel      (clr_all),
        .bus_cycles  (tmr_bus),
        .conv_cycles (tmr_conv),
        .conv_tick   (conversion_clock_tick),
        .done        (tmr_done),
        .busy        ()
    );

    // Configuration registers
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prs_r                 <= `AFC_PRS_RST;
            result_justify_select <= `AFC_JUSTIFY_RST;
            resolution_select     <= `AFC_RES_RST;
        end else begin
            if (wr_prs && cfg_ok) begin
                prs_r <= bus_wdata[6:0];
            end
            if (wr_fmt && cfg_ok) begin
                result_justify_select <= bus_wdata[`AFC_BIT_JUSTIFY];
                resolution_select     <= bus_wdata[2:0];
            end
        end
    end

    // Enable latency counter
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_cnt_r <= 2'h0;
        end else if (!adc_enable) begin
            en_cnt_r <= 2'h0;
        end else if (en_cnt_r != `AFC_EN_LATENCY) begin
            en_cnt_r <= en_cnt_r + 2'h1;
        end
    end

    // Flow bits; a set in the same cycle as a clear wins, except against disable or soft reset
    always @* begin
        sequence_abort_bit_nxt = (req_abort || auto_abort) ||
                   (sequence_abort_bit && !st_idle);
        list_restart_bit_nxt = req_restart ||
                   (list_restart_bit && !loaded);
        sequence_start_bit_nxt = req_start || (trigger_mode && req_restart) ||
                   (sequence_start_bit &&
                    !(loaded && trigger_mode) &&
                    !sample_start);
        alternate_list_loaded_bit_nxt = command_list_buffer_mode &&
                   (req_alternate_list_loaded_bit ||
                    (alternate_list_loaded_bit && !list_swap));
        if (clr_all) begin
            sequence_abort_bit_nxt = 1'b0;
            list_restart_bit_nxt = 1'b0;
            sequence_start_bit_nxt = 1'b0;
            alternate_list_loaded_bit_nxt = 1'b0;
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sequence_abort_bit        <= `AFC_FLOW_RST;
            sequence_start_bit        <= `AFC_FLOW_RST;
            list_restart_bit          <= `AFC_FLOW_RST;
            alternate_list_loaded_bit <= `AFC_FLOW_RST;
        end else begin
            sequence_abort_bit        <= sequence_abort_bit_nxt;
            sequence_start_bit        <= sequence_start_bit_nxt;
            list_restart_bit          <= list_restart_bit_nxt;
            alternate_list_loaded_bit <= alternate_list_loaded_bit_nxt;
        end
    end

    // Sticky flags: 0 command, 1 start overrun, 2 restart, 3 overrun
    assign err_set[0] = start_now && res_bad;
    assign err_set[1] = (req_start && sequence_start_bit) ||
                        (!trigger_mode && req_start && req_restart);
    assign err_set[2] = auto_abort;
    assign err_set[3] = (req_abort && sequence_abort_bit) ||
                        (req_restart && list_restart_bit);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_err
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    err_r[gi] <= 1'b0;
                end else if (err_set[gi]) begin
                    err_r[gi] <= 1'b1;
                end else if (error_flag_clear[gi] || soft_reset) begin
                    err_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign command_error_flag            = err_r[0];
    assign start_overrun_error_flag      = err_r[1];
    assign unexpected_restart_error_flag = err_r[2];
    assign flow_overrun_flag             = err_r[3];

    // Sequence state machine
    always @* begin
        state_nxt = state_r;
        tmr_start = 1'b0;
        tmr_bus   = 3'h0;
        tmr_conv  = 2'h0;
        case (state_r)
            ST_IDLE: begin
                if (list_restart_bit) begin
                    state_nxt = ST_LOAD;
                end else if (sequence_start_bit) begin
                    tmr_start = 1'b1;
                    tmr_bus   = `AFC_RSTM_BUS_CYC;
                    tmr_conv  = `AFC_RSTM_CONV_CYC;
                    state_nxt = ST_WAIT;
                end
            end
            ST_LOAD: begin
                if (first_cmd_loaded) begin
                    if (trigger_mode) begin
                        tmr_start = 1'b1;
                        tmr_bus   = `AFC_TRGM_BUS_CYC;
                        tmr_conv  = `AFC_TRGM_CONV_CYC;
                        state_nxt = ST_WAIT;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (tmr_done) begin
                    state_nxt = res_bad ? ST_HALT : ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_period_end) begin
                    if (sequence_abort_bit || end_of_list) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        tmr_start = 1'b1;
                        tmr_bus   = `AFC_B2B_BUS_CYC;
                        tmr_conv  = `AFC_B2B_CONV_CYC;
                        state_nxt = ST_WAIT;
                    end
                end
            end
            ST_HALT: begin
                state_nxt = ST_HALT;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (clr_all) begin
            state_nxt = ST_IDLE;
            tmr_start = 1'b0;
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Read data; unmapped offsets read zero
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
                `AFC_OFS_PRESCALER: begin
                    bus_rdata <= {1'b0, prs_r};
                end
                `AFC_OFS_FORMAT: begin
                    bus_rdata <= {result_justify_select, 4'h0,
                                  resolution_select};
                end
                `AFC_OFS_FLOW: begin
                    bus_rdata <= {sequence_abort_bit, sequence_start_bit,
                                  list_restart_bit,
                                  alternate_list_loaded_bit, 4'h0};
                end
                default: begin
                    bus_rdata <= 8'h00;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== core/afc_defines.vh ====
// Constants of the converter timing, format and flow control block
`ifndef AFC_DEFINES_VH
`define AFC_DEFINES_VH

// Register offsets on the CPU data bus
`define AFC_OFS_PRESCALER   4'h3
`define AFC_OFS_FORMAT      4'h4
`define AFC_OFS_FLOW        4'h5

// Field positions
`define AFC_BIT_ABORT       7
`define AFC_BIT_START       6
`define AFC_BIT_RESTART     5
`define AFC_BIT_ALTERNATE_LIST_LOADED_BIT        4
`define AFC_BIT_JUSTIFY     7

// Reset values
`define AFC_PRS_RST         7'h00
`define AFC_JUSTIFY_RST     1'h0
`define AFC_RES_RST         3'h0
`define AFC_FLOW_RST        1'h0

// Resolution codes
`define AFC_RES_8BIT        3'h0
`define AFC_RES_10BIT       3'h2

// Control source selection
`define AFC_SRC_BUS         2'h1
`define AFC_SRC_INTF        2'h2

// Timing counts in bus cycles and conversion clock cycles
`define AFC_EN_LATENCY      2'h3
`define AFC_RSTM_BUS_CYC    3'h2
`define AFC_RSTM_CONV_CYC   2'h2
`define AFC_B2B_BUS_CYC     3'h5
`define AFC_B2B_CONV_CYC    2'h2
`define AFC_TRGM_BUS_CYC    3'h5
`define AFC_TRGM_CONV_CYC   2'h0

`endif

// ==== core/afc_timer.v ====
// Delay timer: bus cycles first, then conversion clock ticks
`timescale 1ns/1ps
`default_nettype none

module afc_timer (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       start,
    input  wire       cancel,
    input  wire [2:0] bus_cycles,
    input  wire [1:0] conv_cycles,
    input  wire       conv_tick,
    output wire       done,
    output reg        busy
);

    reg [2:0] bus_cnt_r;
    reg [1:0] conv_cnt_r;

    assign done = busy && (bus_cnt_r == 3'h0) && (conv_cnt_r == 2'h0);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy       <= 1'b0;
            bus_cnt_r  <= 3'h0;
            conv_cnt_r <= 2'h0;
        end else if (cancel) begin
            busy       <= 1'b0;
            bus_cnt_r  <= 3'h0;
            conv_cnt_r <= 2'h0;
        end else if (start) begin
            busy       <= 1'b1;
            bus_cnt_r  <= bus_cycles;
            conv_cnt_r <= conv_cycles;
        end else if (busy) begin
            if (bus_cnt_r != 3'h0) begin
                bus_cnt_r <= bus_cnt_r - 3'h1;
            end else if (conv_cnt_r != 2'h0) begin
                if (conv_tick) begin
                    conv_cnt_r <= conv_cnt_r - 2'h1;
                end
            end else begin
                busy <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== verification/afc_core_model.sv ====
// Converter core stand-in: loads the first command and times conversions
`timescale 1ns/1ps
`default_nettype none

module afc_core_model #(
    parameter int LOAD_DLY = 3,
    parameter int CONV_LEN = 12
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic load_first_cmd,
    input  wire logic sample_start,
    output var  logic first_cmd_loaded,
    output var  logic conv_period_end,
    output wire logic end_of_list
);
    int ld_cnt;
    int cv_cnt;
    int n_conv;
    // Two-command list, so both back-to-back and end of list occur
    assign end_of_list = (n_conv == 1);
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ld_cnt <= 0;
            cv_cnt <= 0;
            n_conv <= 0;
            first_cmd_loaded <= 1'h0;
            conv_period_end <= 1'h0;
        end else begin
            ld_cnt <= (load_first_cmd && !first_cmd_loaded) ? ld_cnt + 1 : 0;
            first_cmd_loaded <= load_first_cmd && ld_cnt == LOAD_DLY;
            cv_cnt <= sample_start ? 1 :
                      (cv_cnt == CONV_LEN ? 0 : cv_cnt + (cv_cnt != 0));
            conv_period_end <= cv_cnt == CONV_LEN;
            if (first_cmd_loaded)
                n_conv <= 0;
            else if (conv_period_end)
                n_conv <= n_conv + 1;
        end
    end
endmodule

`default_nettype wire

// ==== verification/afc_ctrl_bench.sv ====
// Self-checking bench of the conversion timing and flow control block
`timescale 1ns/1ps
`default_nettype none

module afc_ctrl_bench;
    logic       core_clk = 1'h0, rst = 1'h1, bus_wr = 1'h0, bus_rd = 1'h0;
    logic       adc_enable = 1'h0, soft_reset = 1'h0, unlock = 1'h0;
    logic       trg_mode = 1'h0, dbl_buf = 1'h0, loadok = 1'h0;
    logic       abort_req = 1'h0, start_req = 1'h0, restart_req = 1'h0;
    logic [1:0] src = 2'h1;
    logic [3:0] bus_addr = 4'h0, flag_clr = 4'h0;
    logic [7:0] bus_wdata = 8'h00;
    wire  [7:0] bus_rdata;
    wire  [2:0] res;
    wire        tick, justify, res10, load, smp, idle, loaded, pend, swp;
    wire        eol, abt, stt, rsa, ldk, cmd_err, st_err, rs_err, ovr;
    int         num_errors = 0;
    int         tests_run = 0;
    logic       swapped = 1'h0;
    wire  [7:0] mon = {!stt, cmd_err, tick, !abt, pend, !rsa, idle, smp};

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) swapped <= swapped || swp;

    afc_ctrl i_afc_ctrl (
        .core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .adc_enable(adc_enable),
        .soft_reset(soft_reset), .special_access_unlock(unlock),
        .control_source_config(src), .trigger_mode(trg_mode),
        .command_list_buffer_mode(dbl_buf), .intf_abort_req(abort_req),
        .intf_start_req(start_req), .intf_restart_req(restart_req),
        .intf_loadok(loadok), .first_cmd_loaded(loaded),
        .conv_period_end(pend), .end_of_list(eol),
        .error_flag_clear(flag_clr), .conversion_clock(),
        .conversion_clock_tick(tick), .result_justify_select(justify),
        .resolution_select(res), .res_is_10bit(res10),
        .load_first_cmd(load), .list_swap(swp), .sample_start(smp),
        .sequence_active(), .converter_idle(idle),
        .sequence_abort_bit(abt), .sequence_start_bit(stt),
        .list_restart_bit(rsa), .alternate_list_loaded_bit(ldk),
        .command_error_flag(cmd_err), .start_overrun_error_flag(st_err),
        .unexpected_restart_error_flag(rs_err), .flow_overrun_flag(ovr)
    );
    afc_core_model i_afc_core_model (
        .core_clk(core_clk), .rst(rst), .load_first_cmd(load),
        .sample_start(smp), .first_cmd_loaded(loaded),
        .conv_period_end(pend), .end_of_list(eol)
    );

    task automatic conclude;
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Full-byte writes only; single-bit set/clear would disturb flow bits
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_wr <= 1'h1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_rd <= 1'h1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd <= 1'h0;
        #1 chk("bus_rdata", e, bus_rdata);
    endtask
    task automatic wt(input int i, input int n, output int c);
        c = 0;
        #1;
        while (mon[i] !== 1'h1 && c < n) begin
            @(posedge core_clk);
            #1 c++;
        end
        chk("wait", 8'h01, mon[i]);
    endtask
    task automatic pulse(input int k);
        @(posedge core_clk);
        case (k)
            0: abort_req <= 1'h1;
            1: start_req <= 1'h1;
            2: restart_req <= 1'h1;
            default: flag_clr <= 4'hF;
        endcase
        @(posedge core_clk);
        {abort_req, start_req, restart_req, flag_clr} <= 7'h00;
        #1;
    endtask
    task automatic adc_en(input logic v);
        @(posedge core_clk);
        adc_enable <= v;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic srst;
        @(posedge core_clk);
        soft_reset <= 1'h1;
        @(posedge core_clk);
        soft_reset <= 1'h0;
        #1 chk("flow bits", 8'h00, {abt, stt, rsa, ldk, cmd_err, ovr});
        repeat (4) @(posedge core_clk);
    endtask

    task automatic t_regs;
        rd(4'h5, 8'h00);
        rd(4'hF, 8'h00);
        wr(4'h3, 8'h01);
        wr(4'h4, 8'h02);
        rd(4'h3, 8'h01);
        chk("res10", 8'h01, res10);
        adc_en(1'h1);
        wr(4'h3, 8'h7F);
        wr(4'h4, 8'h80);
        rd(4'h3, 8'h01);
        rd(4'h4, 8'h02);
        unlock <= 1'h1;
        wr(4'h4, 8'h80);
        unlock <= 1'h0;
        chk("format", 8'h10, {justify, res, res10});
    endtask
    task automatic t_seq;
        int c;
        wr(4'h5, 8'h20);
        wt(2, 40, c);
        wr(4'h5, 8'h40);
        wr(4'h5, 8'h40);
        chk("start err", 8'h03, {stt, st_err});
        wt(0, 40, c);
        @(posedge core_clk);
        #1 chk("start bit", 8'h00, stt);
        wt(5, 20, c);
        @(posedge core_clk);
        wt(5, 20, c);
        chk("tick gap", 8'h04, c + 1);
        wt(3, 40, c);
        @(posedge core_clk);
        wt(0, 40, c);
        chk("b2b gap", 8'h01, c >= 6 && c <= 16);
        wt(1, 80, c);
        pulse(3);
        chk("flag clear", 8'h00, st_err);
    endtask
    task automatic t_abort;
        int c;
        wr(4'h5, 8'h20);
        wt(2, 40, c);
        wr(4'h5, 8'h40);
        wt(0, 40, c);
        wr(4'h5, 8'h20);
        chk("auto abort", 8'h03, {abt, rs_err});
        wr(4'h5, 8'h80);
        chk("abort ovr", 8'h03, {abt, ovr});
        wr(4'h5, 8'h00);
        chk("zero write", 8'h01, abt);
        wt(4, 60, c);
        wt(2, 60, c);
    endtask
    task automatic t_intf;
        int c;
        srst;
        @(posedge core_clk);
        src <= 2'h2;
        trg_mode <= 1'h1;
        dbl_buf <= 1'h1;
        loadok <= 1'h1;
        pulse(2);
        chk("restart+start", 8'h07, {rsa, stt, ldk});
        pulse(1);
        chk("start err", 8'h01, st_err);
        wt(7, 40, c);
        chk("both clear", 8'h00, {rsa, ldk});
        chk("list swap", 8'h01, swapped);
        wt(0, 20, c);
        chk("sequence_start_bit delay", 8'h01, c >= 4 && c <= 7);
        pulse(0);
        pulse(0);
        chk("abort ovr", 8'h01, ovr);
        wt(4, 80, c);
        adc_en(1'h0);
        rd(4'h5, 8'h00);
    endtask
    task automatic t_resv;
        int c;
        wr(4'h4, 8'h01);
        @(posedge core_clk);
        src <= 2'h1;
        trg_mode <= 1'h0;
        dbl_buf <= 1'h0;
        adc_en(1'h1);
        wr(4'h5, 8'h30);
        chk("single alternate_list_loaded_bit", 8'h00, ldk);
        wt(2, 40, c);
        wr(4'h5, 8'h40);
        wt(6, 60, c);
        srst;
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'h0;
        t_regs;
        t_seq;
        t_abort;
        t_intf;
        t_resv;
        conclude;
    end
    initial begin
        #100000;
        num_errors++;
        conclude;
    end
endmodule

`default_nettype wire

// ==== verification/afc_ctrl_properties.sv ====
// Port-level checks of the conversion timing and flow control block
`timescale 1ns/1ps
`default_nettype none

module afc_ctrl_properties (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [3:0] bus_addr,
    input wire logic       bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic       adc_enable,
    input wire logic       soft_reset,
    input wire logic       special_access_unlock,
    input wire logic [1:0] control_source_config,
    input wire logic       trigger_mode,
    input wire logic       intf_abort_req,
    input wire logic       intf_start_req,
    input wire logic       converter_idle,
    input wire logic       sample_start,
    input wire logic       result_justify_select,
    input wire logic [2:0] resolution_select,
    input wire logic       sequence_abort_bit,
    input wire logic       sequence_start_bit,
    input wire logic       list_restart_bit,
    input wire logic       alternate_list_loaded_bit,
    input wire logic       start_overrun_error_flag,
    input wire logic       flow_overrun_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire       on = adc_enable && !soft_reset;
    wire       fmt_wr = bus_wr && bus_addr == 4'h4;
    wire [3:0] fmt_new = {bus_wdata[7], bus_wdata[2:0]};
    wire       fl_bus = bus_wr && bus_addr == 4'h5 && on
                        && control_source_config == 2'h1;
    wire       intf = on && control_source_config == 2'h2;
    wire       any_bit = sequence_abort_bit || sequence_start_bit
                         || list_restart_bit || alternate_list_loaded_bit;

    chk_fmt_locked: assert property (
        fmt_wr && adc_enable && !special_access_unlock |=>
        $stable({result_justify_select, resolution_select}))
        else $error("format changed while locked");
    chk_fmt_written: assert property (
        fmt_wr && (!adc_enable || special_access_unlock) |=>
        {result_justify_select, resolution_select} == $past(fmt_new))
        else $error("format write lost");
    chk_flow_cleared: assert property (
        !on |=> !any_bit) else $error("flow bit set while disabled");
    chk_enable_latency: assert property (
        $rose(adc_enable) |-> !any_bit [*3])
        else $error("flow bit set inside enable latency");
    chk_abort_overrun: assert property (
        ((fl_bus && bus_wdata[7]) || (intf && intf_abort_req))
        && sequence_abort_bit |=> flow_overrun_flag)
        else $error("repeated abort not flagged");
    chk_start_overrun: assert property (
        ((fl_bus && bus_wdata[6]) || (intf && intf_start_req))
        && sequence_start_bit |=> start_overrun_error_flag)
        else $error("repeated start not flagged");
    chk_abort_when_idle: assert property (
        $fell(sequence_abort_bit) && $past(on) |-> $past(converter_idle))
        else $error("abort bit cleared while busy");
    chk_start_at_sample: assert property (
        $fell(sequence_start_bit) && $past(on) && !trigger_mode
        |-> $past(sample_start)) else $error("start bit cleared early");
    chk_reserved_halts: assert property (
        sample_start |-> resolution_select inside {3'h0, 3'h2})
        else $error("sampling with reserved resolution");
endmodule

bind afc_ctrl afc_ctrl_properties i_afc_ctrl_properties (.*);

`default_nettype wire
